// ===== pkg/srsd_pkg.sv
// Package of constants and types for the reset and sense decode block
package srsd_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RESET_CMD = 8'h04;
  localparam logic [7:0] OFS_ISR = 8'h08;
  localparam logic [7:0] OFS_SENSE0 = 8'h0C;
  localparam logic [7:0] OFS_SENSE1 = 8'h10;
  localparam logic [7:0] OFS_DECODE = 8'h14;
  localparam logic [7:0] OFS_INFO = 8'h18;
  localparam logic [7:0] OFS_DEVDEP = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h24;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h28;
  // Sense byte field positions and values, and the global reset target
  localparam int BIT_VALID = 7;
  localparam int CLASS_HI = 6;
  localparam int CLASS_LO = 4;
  localparam int BIT_FILEMARK = 7;
  localparam int BIT_EOM = 6;
  localparam int BIT_ILI = 5;
  localparam logic [2:0] CLASS_BASIC = 3'h0;
  localparam logic [2:0] CLASS_EXT = 3'h7;
  localparam logic [3:0] CODE_STD = 4'h0;
  localparam logic [3:0] CODE_DEVDEP = 4'hF;
  localparam logic [3:0] DEV_GLOBAL = 4'hF;
  // Interrupt status codes
  localparam logic [7:0] ISR_IMM_DONE = 8'h0A;
  localparam logic [7:0] ISR_DIAG_FAIL = 8'h7F;
  localparam logic [7:0] ISR_RESET_VAL = 8'h00;
  // Bus reset hold time and device reset message length
  localparam int CLK_MHZ = 40;
  localparam int BUS_RST_US = 25;
  localparam int BUS_RST_CYC = BUS_RST_US * CLK_MHZ;
  localparam int MSG_CYC = 4;
  // Interrupt bit positions
  localparam int IRQ_RESET_DONE = 0;
  localparam int IRQ_SENSE_DONE = 1;
  localparam int IRQ_W = 2;
  typedef enum logic [3:0] {
    SRSD_IDLE = 4'b0001,
    SRSD_MSG = 4'b0010,
    SRSD_BUSRST = 4'b0100,
    SRSD_DONE = 4'b1000
  } srsd_state_t;
  typedef enum logic [1:0] {
    SRSD_FMT_BASIC = 2'h0,
    SRSD_FMT_EXT = 2'h1,
    SRSD_FMT_DEVDEP = 2'h2
  } srsd_fmt_t;
  typedef enum logic [1:0] {
    SRSD_CODE_STANDARD = 2'h0,
    SRSD_CODE_RESERVED = 2'h1,
    SRSD_CODE_DEVICE = 2'h2
  } srsd_code_t;
endpackage

// ===== hdl/srsd_sense_mem.sv
// Small memory holding the incoming sense bytes, registered read data
`timescale 1ns/1ps
module srsd_sense_mem #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic aclk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    rd_data <= mem[rd_addr];
  end
endmodule

// ===== hdl/srsd_top.sv
// Sense data decoder and immediate reset command executor with AXI4-Lite registers
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module srsd_top #(
  parameter int BUS_RST_CYCLES = srsd_pkg::BUS_RST_CYC,
  parameter int SENSE_DEPTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sense_valid,
  input wire logic [7:0] sense_byte,
  input wire logic sense_last,
  input wire logic diag_fail,
  output logic bus_reset,
  output logic bdr_msg,
  output logic [3:0] bdr_target,
  output logic activity_halt,
  output logic irq
);
  localparam int SAW = $clog2(SENSE_DEPTH);

  localparam int IRQ_W_L = srsd_pkg::IRQ_W;

  srsd_pkg::srsd_state_t state;
  srsd_pkg::srsd_state_t next_state;
  logic [31:0] cnt;
  logic [3:0] target;
  logic [7:0] isr;
  logic [IRQ_W_L-1:0] irq_status;
  logic [IRQ_W_L-1:0] irq_enable;
  logic diag_q1;
  logic diag_q2;
  logic [SAW-1:0] sense_ptr;
  logic [SAW-1:0] rd_idx;
  logic [7:0] mem_q;
  logic [7:0] sb0;
  logic [7:0] sb1;
  logic [7:0] sb2;
  logic [7:0] sb3;
  logic [31:0] info;
  logic [7:0] sense_count;
  logic sense_done_ev;
  logic reset_done_ev;
  logic reset_start;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic sense_in_q1;
  logic sense_in_q2;

  // Class decoding is used by both the decode register and the info gate
  function automatic srsd_pkg::srsd_fmt_t fmt_of(input logic [7:0] b0);
    if (b0[srsd_pkg::CLASS_HI:srsd_pkg::CLASS_LO] == srsd_pkg::CLASS_BASIC) begin
      fmt_of = srsd_pkg::SRSD_FMT_BASIC;
    end else if (b0[srsd_pkg::CLASS_HI:srsd_pkg::CLASS_LO] == srsd_pkg::CLASS_EXT) begin
      fmt_of = srsd_pkg::SRSD_FMT_EXT;
    end else begin
      fmt_of = srsd_pkg::SRSD_FMT_DEVDEP;
    end
  endfunction

  function automatic srsd_pkg::srsd_code_t code_of(input logic [3:0] c);
    if (c == srsd_pkg::CODE_STD) begin
      code_of = srsd_pkg::SRSD_CODE_STANDARD;
    end else if (c == srsd_pkg::CODE_DEVDEP) begin
      code_of = srsd_pkg::SRSD_CODE_DEVICE;
    end else begin
      code_of = srsd_pkg::SRSD_CODE_RESERVED;
    end
  endfunction

  // AXI4-Lite write channel: address and data taken in either order
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr <= srsd_pkg::OFS_IRQ_CLEAR && aw_addr[1:0] == 2'b00)
                       ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Reset command launch: a write to the reset register with the low byte lane
  assign reset_start = do_write && aw_addr == srsd_pkg::OFS_RESET_CMD && w_strb[0]
                       && state == srsd_pkg::SRSD_IDLE;

  // Irq enable register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable <= '0;
    end else if (do_write && aw_addr == srsd_pkg::OFS_IRQ_ENABLE && w_strb[0]) begin
      irq_enable <= w_data[IRQ_W_L-1:0];
    end
  end

  // Reset command sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      srsd_pkg::SRSD_IDLE: begin
        if (reset_start) begin
          next_state = (w_data[3:0] == srsd_pkg::DEV_GLOBAL)
                       ? srsd_pkg::SRSD_BUSRST : srsd_pkg::SRSD_MSG;
        end
      end
      srsd_pkg::SRSD_MSG: begin
        if (cnt == 32'(srsd_pkg::MSG_CYC - 1)) begin
          next_state = srsd_pkg::SRSD_DONE;
        end
      end
      srsd_pkg::SRSD_BUSRST: begin
        if (cnt == 32'(BUS_RST_CYCLES - 1)) begin
          next_state = srsd_pkg::SRSD_DONE;
        end
      end
      srsd_pkg::SRSD_DONE: begin
        next_state = srsd_pkg::SRSD_IDLE;
      end
      default: begin
        next_state = srsd_pkg::SRSD_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= srsd_pkg::SRSD_IDLE;
      cnt <= 32'h0000_0000;
      target <= 4'h0;
    end else begin
      state <= next_state;
      cnt <= (next_state != state) ? 32'h0000_0000 : cnt + 32'h0000_0001;
      if (reset_start) begin
        target <= w_data[3:0];
      end
    end
  end

  // Link-facing outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_reset <= 1'b0;
      activity_halt <= 1'b0;
      bdr_msg <= 1'b0;
      bdr_target <= 4'h0;
    end else begin
      bus_reset <= next_state == srsd_pkg::SRSD_BUSRST;
      activity_halt <= next_state == srsd_pkg::SRSD_BUSRST;
      bdr_msg <= next_state == srsd_pkg::SRSD_MSG;
      if (reset_start) begin
        bdr_target <= w_data[3:0];
      end
    end
  end

  assign reset_done_ev = state == srsd_pkg::SRSD_DONE;

  // Interrupt status register; diagnostic failure overrides completion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      isr <= srsd_pkg::ISR_RESET_VAL;
    end else if (diag_q2) begin
      isr <= srsd_pkg::ISR_DIAG_FAIL;
    end else if (reset_done_ev) begin
      isr <= srsd_pkg::ISR_IMM_DONE;
    end
  end

  // Diagnostic flag comes from another domain, so two flops before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      diag_q1 <= 1'b0;
      diag_q2 <= 1'b0;
    end else begin
      diag_q1 <= diag_fail;
      diag_q2 <= diag_q1;
    end
  end

  // Sense byte capture; bytes arrive from the target-side logic on aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_ptr <= '0;
      sense_count <= 8'h00;
      sb0 <= 8'h00;
      sb1 <= 8'h00;
      sb2 <= 8'h00;
      sb3 <= 8'h00;
      info <= 32'h0000_0000;
    end else if (sense_valid) begin
      sense_ptr <= sense_last ? '0 : sense_ptr + 1'b1;
      sense_count <= sense_last ? 8'(sense_ptr) + 8'h01 : sense_count;
      unique case (sense_ptr)
        SAW'(0): sb0 <= sense_byte;
        SAW'(1): sb1 <= sense_byte;
        SAW'(2): sb2 <= sense_byte;
        SAW'(3): sb3 <= sense_byte;
        default: sb0 <= sb0;
      endcase
      if (sense_ptr >= SAW'(3) && sense_ptr <= SAW'(6)) begin
        info <= {info[23:0], sense_byte};
      end
    end
  end

  // Completion of a whole sense block raises an event
  assign sense_done_ev = sense_valid && sense_last;

  // Sticky status: set wins over clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
    end else begin
      logic [IRQ_W_L-1:0] clr;
      logic [IRQ_W_L-1:0] set;
      clr = (do_write && aw_addr == srsd_pkg::OFS_IRQ_CLEAR && w_strb[0])
            ? w_data[IRQ_W_L-1:0] : '0;
      set = '0;
      set[srsd_pkg::IRQ_RESET_DONE] = reset_done_ev || diag_q2;
      set[srsd_pkg::IRQ_SENSE_DONE] = sense_done_ev;
      irq_status <= (irq_status & ~clr) | set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_enable);
    end
  end

  // Raw sense bytes readable by index
  srsd_sense_mem #(
    .DEPTH(SENSE_DEPTH),
    .AW(SAW)
  ) u_mem (
    .aclk(aclk),
    .wr_en(sense_valid),
    .wr_addr(sense_ptr),
    .wr_data(sense_byte),
    .rd_addr(rd_idx),
    .rd_data(mem_q)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_idx <= '0;
    end else if (do_write && aw_addr == srsd_pkg::OFS_CTRL && w_strb[0]) begin
      rd_idx <= w_data[SAW-1:0];
    end
  end

  // Decoded view of the sense block
  function automatic logic [31:0] decode_word(input logic [7:0] b0, input logic [7:0] b2);
    srsd_pkg::srsd_fmt_t f;
    f = fmt_of(b0);
    decode_word = 32'h0000_0000;
    decode_word[1:0] = f;
    if (f == srsd_pkg::SRSD_FMT_BASIC) begin
      decode_word[2] = b0[srsd_pkg::BIT_VALID];
    end else if (f == srsd_pkg::SRSD_FMT_EXT) begin
      decode_word[3] = b0[srsd_pkg::BIT_VALID];
      decode_word[5:4] = code_of(b0[3:0]);
      decode_word[6] = b2[srsd_pkg::BIT_FILEMARK];
      decode_word[7] = b2[srsd_pkg::BIT_EOM];
      decode_word[8] = b2[srsd_pkg::BIT_ILI];
      decode_word[15:12] = b2[3:0];
    end
  endfunction

  // AXI4-Lite read channel, one cycle after address taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !s_axi_arvalid ? 1'b0
                       : (!s_axi_arready && !s_axi_rvalid);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        unique case (s_axi_araddr)
          srsd_pkg::OFS_CTRL: s_axi_rdata <= 32'(rd_idx);
          srsd_pkg::OFS_RESET_CMD: s_axi_rdata <= {24'h00_0000, state, target};
          srsd_pkg::OFS_ISR: s_axi_rdata <= {24'h00_0000, isr};
          srsd_pkg::OFS_SENSE0: s_axi_rdata <= {sb3, sb2, sb1, sb0};
          srsd_pkg::OFS_SENSE1: s_axi_rdata <= {24'h00_0000, sense_count};
          srsd_pkg::OFS_DECODE: s_axi_rdata <= decode_word(sb0, sb2);
          srsd_pkg::OFS_INFO: s_axi_rdata <= (fmt_of(sb0) == srsd_pkg::SRSD_FMT_EXT
                                              && sb0[srsd_pkg::BIT_VALID]) ? info
                                             : 32'h0000_0000;
          srsd_pkg::OFS_DEVDEP: s_axi_rdata <= {24'h00_0000, mem_q};
          srsd_pkg::OFS_IRQ_STATUS: s_axi_rdata <= 32'(irq_status);
          srsd_pkg::OFS_IRQ_ENABLE: s_axi_rdata <= 32'(irq_enable);
          srsd_pkg::OFS_IRQ_CLEAR: s_axi_rdata <= 32'h0000_0000;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ===== sim/srsd_top_chk_sva.sv
// Port checker for the reset and sense decode block
`timescale 1ns/1ps
module srsd_top_chk #(
  parameter int BUS_RST_CYCLES = srsd_pkg::BUS_RST_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic bus_reset,
  input wire logic bdr_msg,
  input wire logic [3:0] bdr_target,
  input wire logic activity_halt,
  input wire logic irq
);
  // Counts bus reset high time; a counter avoids a long unrolled repetition
  logic [15:0] hold_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn || !bus_reset) begin
      hold_cnt <= 16'h0000;
    end else begin
      hold_cnt <= hold_cnt + 16'h0001;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_BDR_FOUR: assert property ($rose(bdr_msg) |-> bdr_msg[*4] ##1 !bdr_msg)
    else $error("device reset message length wrong");
  AST_BDR_LOCAL: assert property (bdr_msg |-> bdr_target != 4'hF && !bus_reset)
    else $error("device reset message sent for global target");
  AST_BUS_HOLD: assert property ($fell(bus_reset) |-> hold_cnt == BUS_RST_CYCLES)
    else $error("bus reset hold time wrong");
  AST_HALT_TRACK: assert property (activity_halt == bus_reset)
    else $error("activity halt differs from bus reset");
  AST_GLOBAL_TGT: assert property ($rose(bus_reset) |-> bdr_target == 4'hF)
    else $error("bus reset without global target");
  AST_QUIET_START: assert property ($rose(aresetn) |-> !bus_reset && !bdr_msg && !irq)
    else $error("outputs active after reset");
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  COV_BDR: cover property ($rose(bdr_msg));
  COV_BUSRST: cover property ($rose(bus_reset));
  COV_IRQ: cover property ($rose(irq));
endmodule

bind srsd_top srsd_top_chk #(.BUS_RST_CYCLES(BUS_RST_CYCLES)) u_srsd_top_chk (.aclk, .aresetn,
  .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .bus_reset,
  .bdr_msg, .bdr_target, .activity_halt, .irq);

// ===== sim/srsd_target_model.sv
// Target-side model that hands sense blocks over byte by byte
`timescale 1ns/1ps
module srsd_target_model (
  input wire logic aclk,
  output logic sense_valid,
  output logic [7:0] sense_byte,
  output logic sense_last
);
  initial begin
    sense_valid = 1'b0;
    sense_byte = 8'h00;
    sense_last = 1'b0;
  end
  // Idle cycles show inverted data so sampling without valid is caught
  task automatic send(input logic [7:0] blk[8], input int len, input int gap);
    for (int i = 0; i < len; i++) begin
      @(posedge aclk);
      sense_valid <= 1'b1;
      sense_byte <= blk[i];
      sense_last <= (i == len - 1);
      repeat (gap) begin
        @(posedge aclk);
        sense_valid <= 1'b0;
        sense_last <= 1'b0;
        sense_byte <= ~blk[i];
      end
    end
    @(posedge aclk);
    sense_valid <= 1'b0;
    sense_last <= 1'b0;
    sense_byte <= ~blk[len - 1];
  endtask
endmodule

// ===== sim/test_scsi_reset_and_sense_decode.sv
// Self-checking bench for the reset and sense decode block
`timescale 1ns/1ps
module test_scsi_reset_and_sense_decode;
  localparam int HOLD = 8;
  logic aclk;
  logic aresetn = 1'b0;
  logic diag_fail = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [3:0] bdr_target;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
  logic [31:0] s_axi_rdata, rd_val;
  logic sense_valid, sense_last, bus_reset, bdr_msg, activity_halt, irq;
  logic [7:0] sense_byte;
  int errors = 0;
  int total_checks = 0;

  srsd_top #(.BUS_RST_CYCLES(HOLD)) u_srsd_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sense_valid, .sense_byte, .sense_last,
    .diag_fail, .bus_reset, .bdr_msg, .bdr_target, .activity_halt, .irq);
  srsd_target_model u_srsd_target_model (.aclk, .sense_valid, .sense_byte, .sense_last);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic conclude();
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
    total_checks++;
    if ((got & msk) !== (exp & msk)) begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      errors++;
      $display("FAIL %0t wait ran out", $time);
      conclude();
    end
  endtask

  // Ready is raised only once both valids drop, in the same cycle the slave raises its response
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (!s_axi_awvalid && !s_axi_wvalid) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 300);
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(n, 300);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (!s_axi_arvalid) s_axi_rready <= 1'b1;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 300);
    rd_val = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n, 300);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rd(a);
    chk(rd_val, e, m);
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    tmo(n, 3000);
  endtask

  task automatic sense(input logic [2:0] cls, input logic [3:0] k);
    logic [7:0] b[8];
    int n;
    int idx;
    logic [31:0] e, m, inf;
    n = (cls == 3'h7) ? 8 : 4;
    foreach (b[i]) b[i] = 8'($urandom());
    b[0][6:4] = cls;
    if (cls == 3'h7) begin
      b[0][3:0] = k;
      b[2][3:0] = k;
    end
    u_srsd_target_model.send(b, n, int'($urandom_range(2)));
    wait_irq();
    rchk(8'h20, 32'h0000_0002, 32'h0000_0002);
    wr(8'h28, 32'h0000_0002);
    e = 32'h0000_0000;
    e[1:0] = (cls == 3'h0) ? 2'h0 : (cls == 3'h7) ? 2'h1 : 2'h2;
    e[2] = b[0][7];
    e[3] = b[0][7];
    e[5:4] = (k == 4'h0) ? 2'h0 : (k == 4'hF) ? 2'h2 : 2'h1;
    e[8:6] = {b[2][5], b[2][6], b[2][7]};
    e[15:12] = b[2][3:0];
    m = (cls == 3'h7) ? 32'h0000_F1FB : (cls == 3'h0) ? 32'h0000_0007 : 32'h0000_0003;
    rchk(8'h14, e, m);
    inf = (cls == 3'h7 && b[0][7]) ? {b[3], b[4], b[5], b[6]} : 32'h0000_0000;
    rchk(8'h18, inf, 32'hFFFF_FFFF);
    rchk(8'h10, 32'(n), 32'h0000_00FF);
    for (int j = 0; j < 2; j++) begin
      idx = (j == 0) ? 1 : n - 1;
      wr(8'h00, 32'(idx));
      rchk(8'h1C, {24'h00_0000, b[idx]}, 32'h0000_00FF);
    end
  endtask

  initial begin
    void'($urandom(54));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(8'h08, {24'h00_0000, srsd_pkg::ISR_RESET_VAL}, 32'h0000_00FF);
    wr(8'h04, 32'h0000_0003);
    chk({30'h0, wr_resp}, 32'h0000_0000, 32'h0000_0003);
    for (int i = 0; i < 50 && rd_val[0] !== 1'b1; i++) rd(8'h20);
    chk(rd_val, 32'h0000_0001, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000, 32'h0000_0001);
    chk({28'h0, bdr_target}, 32'h0000_0003, 32'h0000_000F);
    wr(8'h24, 32'h0000_0003);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0000_0001, 32'h0000_0001);
    rchk(8'h08, {24'h00_0000, srsd_pkg::ISR_IMM_DONE}, 32'h0000_00FF);
    wr(8'h28, 32'h0000_0001);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0000_0000, 32'h0000_0001);
    wr(8'h04, 32'h0000_000F);
    wr(8'h04, 32'h0000_0005);
    wait_irq();
    chk({28'h0, bdr_target}, 32'h0000_000F, 32'h0000_000F);
    rchk(8'h08, {24'h00_0000, srsd_pkg::ISR_IMM_DONE}, 32'h0000_00FF);
    wr(8'h28, 32'h0000_0001);
    rchk(8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
    chk({30'h0, rd_resp}, 32'h0000_0002, 32'h0000_0003);
    wr(8'h42, 32'h0000_0000);
    chk({30'h0, wr_resp}, 32'h0000_0002, 32'h0000_0003);
    for (int k = 0; k < 16; k++) sense(3'h7, 4'(k));
    for (int c = 0; c < 7; c++) sense(3'(c), 4'h0);
    diag_fail <= 1'b1;
    wait_irq();
    rchk(8'h08, {24'h00_0000, srsd_pkg::ISR_DIAG_FAIL}, 32'h0000_00FF);
    conclude();
  end
endmodule
